//--- cfb_pkg.sv
// Purpose: Shared constants and types of the CAN filter, mask and buffer control block.
// Assumes: One 50 MHz clock, Avalon-MM register access with byte addresses.
// Notes: Registers are 16 bits wide in the low half of each 32-bit word.
`default_nettype none
package cfb_pkg;
	localparam int NUM_FILT = 16;
	localparam int NUM_MASK = 3;
	localparam int NUM_BUF = 32;
	localparam int NUM_TXB = 8;
	localparam int CLK_MHZ = 50;
	localparam int BUS_ANSWER_CYCLES = 1;
	// Register byte offsets.
	localparam logic [7:0] OFS_MSEL_LO = 8'h00;
	localparam logic [7:0] OFS_MSEL_HI = 8'h04;
	localparam logic [7:0] OFS_MASK_BASE = 8'h08;
	localparam logic [7:0] OFS_FEN = 8'h20;
	localparam logic [7:0] OFS_BPTR_BASE = 8'h24;
	localparam logic [7:0] OFS_FULL_LO = 8'h34;
	localparam logic [7:0] OFS_FULL_HI = 8'h38;
	localparam logic [7:0] OFS_OVF_LO = 8'h3C;
	localparam logic [7:0] OFS_OVF_HI = 8'h40;
	localparam logic [7:0] OFS_TXCON_BASE = 8'h44;
	localparam logic [7:0] OFS_FILT_BASE = 8'h80;
	localparam logic [7:0] MASK_STRIDE = 8'h08;
	localparam logic [7:0] FILT_STRIDE = 8'h08;
	localparam logic [7:0] EXT_WORD = 8'h04;
	// Field positions of the identifier words.
	localparam int ID_SID_LSB = 5;
	localparam int ID_TYPE_BIT = 3;
	// Reset values.
	localparam logic [15:0] RST_FEN = 16'hFFFF;
	localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
	// Mask source codes.
	localparam logic [1:0] MSRC_MASK0 = 2'h0;
	localparam logic [1:0] MSRC_MASK1 = 2'h1;
	localparam logic [1:0] MSRC_MASK2 = 2'h2;
	localparam logic [1:0] MSRC_NONE = 2'h3;
	localparam logic [3:0] BPTR_FIFO = 4'hF;

	typedef struct packed {
		logic [10:0] standard_id_bits;
		logic type_bit;
		logic [17:0] extended_id_bits;
	} cfb_id_t;

	typedef struct packed {
		logic valid;
		logic ide;
		logic rtr;
		logic [10:0] standard_id_bits;
		logic [17:0] extended_id_bits;
	} cfb_rx_t;

	typedef struct packed {
		logic valid;
		logic [2:0] buf_idx;
		logic sent_ok;
		logic aborted;
		logic lost_arb;
		logic bus_err;
	} cfb_txev_t;

	typedef struct packed {
		logic dir;
		logic abt;
		logic larb;
		logic err;
		logic req;
		logic auto_remote_enable;
		logic [1:0] pri;
	} cfb_txcon_t;

	typedef struct packed {
		logic valid;
		logic to_fifo;
		logic [4:0] buf_idx;
		logic [4:0] filter_hit;
	} cfb_store_t;

	typedef struct packed {
		logic [31:0] msel;
		cfb_id_t [NUM_MASK-1:0] mask;
		cfb_id_t [NUM_FILT-1:0] filt;
		logic [15:0] fen;
		logic [NUM_FILT-1:0][3:0] bptr;
		logic [31:0] full;
		logic [31:0] ovf;
		cfb_txcon_t [NUM_TXB-1:0] txcon;
		logic [NUM_TXB-1:0] abort_req;
		logic wait_rq;
		logic [31:0] rdata;
		cfb_store_t store;
		logic pick_valid;
		logic [2:0] pick_idx;
	} cfb_state_t;
endpackage : cfb_pkg
`default_nettype wire

//--- cfb_filter_match.sv
// Purpose: Compares one received identifier against one acceptance filter.
// Assumes: Mask already chosen by the caller; all-ones mask means no mask.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module cfb_filter_match
	import cfb_pkg::*;
(
	// Filter setup.
	input wire cfb_id_t filt_i,
	input wire cfb_id_t mask_i,
	input wire logic enable_i,
	// Received frame.
	input wire cfb_rx_t frame_i,
	// Result.
	output logic hit_o
);
	logic sid_ok;
	logic eid_ok;
	logic type_ok;

	assign sid_ok = ((frame_i.standard_id_bits ^ filt_i.standard_id_bits) & mask_i.standard_id_bits) == 11'h000;
	assign eid_ok = !frame_i.ide || (((frame_i.extended_id_bits ^ filt_i.extended_id_bits) & mask_i.extended_id_bits) == 18'h00000);
	assign type_ok = !mask_i.type_bit || (frame_i.ide == filt_i.type_bit);
	assign hit_o = enable_i && sid_ok && eid_ok && type_ok;
endmodule : cfb_filter_match
`default_nettype wire

//--- cfb_ctrl.sv
// Purpose: Filter mask selection, receive flags and transmit buffer control.
// Assumes: Protocol engine and DMA logic share core_clk_i.
// Notes: Avalon-MM slave answers one cycle after a request is seen.
`timescale 1ns/1ps
`default_nettype none
module cfb_ctrl
	import cfb_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave.
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Protocol engine events.
	input wire cfb_rx_t rx_frame_i,
	input wire cfb_txev_t tx_event_i,
	// Store requests to the DMA message memory.
	output cfb_store_t rx_store_o,
	// Transmit scheduling.
	output logic tx_pick_valid_o,
	output logic [2:0] tx_pick_buf_o,
	output logic [NUM_TXB-1:0] tx_abort_o
);
	cfb_state_t st;
	cfb_state_t nx;
	cfb_id_t [NUM_FILT-1:0] fmask;
	logic [NUM_FILT-1:0] hits;
	logic [7:0] addr_w;
	logic wr_ack;
	logic [15:0] wd;
	logic [15:0] rd_val;
	logic [15:0] clr;
	logic found;
	logic [3:0] fidx;
	logic [3:0] ptr;
	logic [4:0] bidx;
	logic old_req;
	logic [2:0] best_b;
	logic [1:0] best_p;
	logic any_higher;
	logic [NUM_TXB-1:0] pend;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be);
		merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic [15:0] std_word(input cfb_id_t x);
		std_word = {x.standard_id_bits, 1'b0, x.type_bit, 1'b0, x.extended_id_bits[17:16]};
	endfunction : std_word

	// Mask chosen for each filter.
	always_comb
	begin
		for (int f = 0; f < NUM_FILT; f++)
		begin
			unique case (st.msel[2*f +: 2])
				MSRC_MASK0: fmask[f] = st.mask[0];
				MSRC_MASK1: fmask[f] = st.mask[1];
				MSRC_MASK2: fmask[f] = st.mask[2];
				MSRC_NONE: fmask[f] = '1;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_FILT; g++)
		begin : g_filt
			cfb_filter_match u_match (
				.filt_i(st.filt[g]),
				.mask_i(fmask[g]),
				.enable_i(st.fen[g]),
				.frame_i(rx_frame_i),
				.hit_o(hits[g])
			);
		end
	endgenerate

	assign addr_w = {avs_address_i[7:2], 2'b00};
	assign wr_ack = avs_write_i && !st.wait_rq;
	assign wd = avs_writedata_i[15:0];

	// Read multiplexer; unmapped words read as zero.
	always_comb
	begin
		rd_val = 16'h0000;
		if (addr_w == OFS_MSEL_LO) rd_val = st.msel[15:0];
		if (addr_w == OFS_MSEL_HI) rd_val = st.msel[31:16];
		if (addr_w == OFS_FEN) rd_val = st.fen;
		if (addr_w == OFS_FULL_LO) rd_val = st.full[15:0];
		if (addr_w == OFS_FULL_HI) rd_val = st.full[31:16];
		if (addr_w == OFS_OVF_LO) rd_val = st.ovf[15:0];
		if (addr_w == OFS_OVF_HI) rd_val = st.ovf[31:16];
		for (int m = 0; m < NUM_MASK; m++)
		begin
			if (addr_w == OFS_MASK_BASE + 8'(m) * MASK_STRIDE) rd_val = std_word(st.mask[m]);
			if (addr_w == OFS_MASK_BASE + 8'(m) * MASK_STRIDE + EXT_WORD)
				rd_val = st.mask[m].extended_id_bits[15:0];
		end
		for (int k = 0; k < NUM_FILT / 4; k++)
		begin
			if (addr_w == OFS_BPTR_BASE + 8'(4 * k))
				rd_val = {st.bptr[4*k+3], st.bptr[4*k+2], st.bptr[4*k+1], st.bptr[4*k]};
		end
		for (int k = 0; k < NUM_TXB / 2; k++)
		begin
			if (addr_w == OFS_TXCON_BASE + 8'(4 * k)) rd_val = {st.txcon[2*k+1], st.txcon[2*k]};
		end
		for (int f = 0; f < NUM_FILT; f++)
		begin
			if (addr_w == OFS_FILT_BASE + 8'(f) * FILT_STRIDE) rd_val = std_word(st.filt[f]);
			if (addr_w == OFS_FILT_BASE + 8'(f) * FILT_STRIDE + EXT_WORD)
				rd_val = st.filt[f].extended_id_bits[15:0];
		end
	end

	// Next state.
	always_comb
	begin
		nx = st;
		clr = 16'h0000;
		found = 1'b0;
		fidx = 4'h0;
		ptr = 4'h0;
		bidx = 5'h00;
		old_req = 1'b0;
		best_b = 3'h0;
		best_p = 2'h0;
		// Bus handshake: hold waitrequest high for one cycle, then accept.
		nx.wait_rq = !((avs_read_i || avs_write_i) && st.wait_rq);
		if (avs_read_i && st.wait_rq)
			nx.rdata = {16'h0000, rd_val};
		// Software writes.
		if (wr_ack)
		begin
			if (addr_w == OFS_MSEL_LO) nx.msel[15:0] = merge16(st.msel[15:0], wd, avs_byteenable_i[1:0]);
			if (addr_w == OFS_MSEL_HI) nx.msel[31:16] = merge16(st.msel[31:16], wd, avs_byteenable_i[1:0]);
			if (addr_w == OFS_FEN) nx.fen = merge16(st.fen, wd, avs_byteenable_i[1:0]);
			clr = {avs_byteenable_i[1] ? ~wd[15:8] : 8'h00, avs_byteenable_i[0] ? ~wd[7:0] : 8'h00};
			if (addr_w == OFS_FULL_LO) nx.full[15:0] = st.full[15:0] & ~clr;
			if (addr_w == OFS_FULL_HI) nx.full[31:16] = st.full[31:16] & ~clr;
			if (addr_w == OFS_OVF_LO) nx.ovf[15:0] = st.ovf[15:0] & ~clr;
			if (addr_w == OFS_OVF_HI) nx.ovf[31:16] = st.ovf[31:16] & ~clr;
			for (int m = 0; m < NUM_MASK; m++)
			begin
				if (addr_w == OFS_MASK_BASE + 8'(m) * MASK_STRIDE)
				begin
					if (avs_byteenable_i[1]) nx.mask[m].standard_id_bits[10:3] = wd[15:8];
					if (avs_byteenable_i[0])
						{nx.mask[m].standard_id_bits[2:0], nx.mask[m].type_bit, nx.mask[m].extended_id_bits[17:16]} =
							{wd[7:5], wd[ID_TYPE_BIT], wd[1:0]};
				end
				if (addr_w == OFS_MASK_BASE + 8'(m) * MASK_STRIDE + EXT_WORD)
					nx.mask[m].extended_id_bits[15:0] = merge16(st.mask[m].extended_id_bits[15:0], wd, avs_byteenable_i[1:0]);
			end
			for (int f = 0; f < NUM_FILT; f++)
			begin
				if (addr_w == OFS_FILT_BASE + 8'(f) * FILT_STRIDE)
				begin
					if (avs_byteenable_i[1]) nx.filt[f].standard_id_bits[10:3] = wd[15:8];
					if (avs_byteenable_i[0])
						{nx.filt[f].standard_id_bits[2:0], nx.filt[f].type_bit, nx.filt[f].extended_id_bits[17:16]} =
							{wd[7:5], wd[ID_TYPE_BIT], wd[1:0]};
				end
				if (addr_w == OFS_FILT_BASE + 8'(f) * FILT_STRIDE + EXT_WORD)
					nx.filt[f].extended_id_bits[15:0] = merge16(st.filt[f].extended_id_bits[15:0], wd, avs_byteenable_i[1:0]);
			end
			for (int k = 0; k < NUM_FILT / 4; k++)
			begin
				if (addr_w == OFS_BPTR_BASE + 8'(4 * k))
					{nx.bptr[4*k+3], nx.bptr[4*k+2], nx.bptr[4*k+1], nx.bptr[4*k]} = merge16(
						{st.bptr[4*k+3], st.bptr[4*k+2], st.bptr[4*k+1], st.bptr[4*k]}, wd,
						avs_byteenable_i[1:0]);
			end
			for (int b = 0; b < NUM_TXB; b++)
			begin
				if (addr_w == OFS_TXCON_BASE + 8'(4 * (b / 2)) && avs_byteenable_i[b % 2])
				begin
					nx.txcon[b].dir = wd[8*(b%2)+7];
					nx.txcon[b].req = wd[8*(b%2)+3];
					nx.txcon[b].auto_remote_enable = wd[8*(b%2)+2];
					nx.txcon[b].pri = wd[8*(b%2) +: 2];
					if (st.txcon[b].req && !nx.txcon[b].req)
						nx.abort_req[b] = 1'b1;
				end
			end
		end
		// Receive: lowest numbered hitting filter wins.
		nx.store = '0;
		for (int f = NUM_FILT - 1; f >= 0; f--)
		begin
			if (hits[f])
			begin
				found = 1'b1;
				fidx = 4'(f);
			end
		end
		if (rx_frame_i.valid && found)
		begin
			ptr = st.bptr[fidx];
			bidx = {1'b0, ptr};
			if (ptr == BPTR_FIFO)
				nx.store = '{valid: 1'b1, to_fifo: 1'b1, buf_idx: 5'h00, filter_hit: {1'b0, fidx}};
			else if (rx_frame_i.rtr && ptr < 4'(NUM_TXB) && st.txcon[ptr[2:0]].dir)
			begin
				if (st.txcon[ptr[2:0]].auto_remote_enable)
					nx.txcon[ptr[2:0]].req = 1'b1;
			end
			else if (nx.full[bidx] || st.full[bidx])
				nx.ovf[bidx] = 1'b1;
			else
			begin
				nx.full[bidx] = 1'b1;
				nx.store = '{valid: 1'b1, to_fifo: 1'b0, buf_idx: bidx, filter_hit: {1'b0, fidx}};
			end
		end
		// Send request newly set clears the status flags.
		for (int b = 0; b < NUM_TXB; b++)
		begin
			old_req = st.txcon[b].req;
			if (!old_req && nx.txcon[b].req)
			begin
				nx.txcon[b].abt = 1'b0;
				nx.txcon[b].larb = 1'b0;
				nx.txcon[b].err = 1'b0;
				nx.abort_req[b] = 1'b0;
			end
		end
		// Engine outcomes are applied last so that a hardware set wins.
		if (tx_event_i.valid)
		begin
			if (tx_event_i.sent_ok)
			begin
				nx.txcon[tx_event_i.buf_idx].req = 1'b0;
				nx.txcon[tx_event_i.buf_idx].abt = 1'b0;
			end
			if (tx_event_i.aborted)
			begin
				nx.txcon[tx_event_i.buf_idx].abt = 1'b1;
				nx.txcon[tx_event_i.buf_idx].req = 1'b0;
				nx.abort_req[tx_event_i.buf_idx] = 1'b0;
			end
			if (tx_event_i.lost_arb)
				nx.txcon[tx_event_i.buf_idx].larb = 1'b1;
			if (tx_event_i.bus_err)
				nx.txcon[tx_event_i.buf_idx].err = 1'b1;
		end
		// Highest priority pending buffer, ties to the higher index.
		nx.pick_valid = 1'b0;
		for (int b = 0; b < NUM_TXB; b++)
		begin
			if (pend[b] && (!nx.pick_valid || st.txcon[b].pri >= best_p))
			begin
				nx.pick_valid = 1'b1;
				best_p = st.txcon[b].pri;
				best_b = 3'(b);
			end
		end
		nx.pick_idx = best_b;
	end

	always_comb
	begin
		any_higher = 1'b0;
		for (int b = 0; b < NUM_TXB; b++)
		begin
			pend[b] = st.txcon[b].dir && st.txcon[b].req && !st.abort_req[b];
			if (pend[b] && st.txcon[b].pri > st.txcon[st.pick_idx].pri)
				any_higher = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st <= '0;
			st.fen <= RST_FEN;
			st.full <= RST_FLAGS;
			st.ovf <= RST_FLAGS;
			st.wait_rq <= 1'b1;
		end
		else
			st <= nx;
	end

	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = st.wait_rq;
	assign rx_store_o = st.store;
	assign tx_pick_valid_o = st.pick_valid;
	assign tx_pick_buf_o = st.pick_idx;
	assign tx_abort_o = st.abort_req;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_bus_answer;
		(avs_read_i || avs_write_i) && st.wait_rq |=> !st.wait_rq ##1 st.wait_rq;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("Bus answer not in one cycle.");

	property p_full_sw_clear;
		(|($past(st.full) & ~st.full)) |-> $past(wr_ack && (addr_w == OFS_FULL_LO || addr_w == OFS_FULL_HI));
	endproperty
	a_full_sw_clear: assert property (p_full_sw_clear) else $error("Full flag cleared without write.");

	property p_store_sets_full;
		st.store.valid && !st.store.to_fifo |-> st.full[st.store.buf_idx];
	endproperty
	a_store_sets_full: assert property (p_store_sets_full) else $error("Stored buffer not full.");

	property p_ovf_cause;
		(|(st.ovf & ~$past(st.ovf))) |-> $past(rx_frame_i.valid) && !st.store.valid;
	endproperty
	a_ovf_cause: assert property (p_ovf_cause) else $error("Overflow without blocked store.");

	property p_sent_clears_req;
		tx_event_i.valid && tx_event_i.sent_ok && !wr_ack && !rx_frame_i.valid
			|=> !st.txcon[$past(tx_event_i.buf_idx)].req;
	endproperty
	a_sent_clears_req: assert property (p_sent_clears_req) else $error("Request kept after send.");

	property p_req_rise_clears;
		$rose(st.txcon[0].req) |-> !st.txcon[0].abt && !st.txcon[0].larb && !st.txcon[0].err;
	endproperty
	a_req_rise_clears: assert property (p_req_rise_clears) else $error("Status kept on new request.");

	property p_abort_on_clear;
		$fell(st.txcon[1].req) && !$past(tx_event_i.valid) |-> st.abort_req[1];
	endproperty
	a_abort_on_clear: assert property (p_abort_on_clear) else $error("Abort not raised.");

	property p_pick_priority;
		st.pick_valid && $stable(st.txcon) && $stable(st.abort_req) |-> !any_higher && pend[st.pick_idx];
	endproperty
	a_pick_priority: assert property (p_pick_priority) else $error("Pick not highest priority.");
endmodule : cfb_ctrl
`default_nettype wire

//--- cfb_engine_model.sv
// Purpose: Behavioural protocol engine that feeds frames and transmit events.
// Assumes: Events are one-cycle pulses on the shared clock.
// Notes: Released fields show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module cfb_engine_model
	import cfb_pkg::*;
(
	// Clock.
	input wire logic core_clk_i,
	// Engine events.
	output var cfb_rx_t rx_frame_o,
	output var cfb_txev_t tx_event_o
);
	initial
	begin
		rx_frame_o = '0;
		tx_event_o = '0;
	end

	// Sends one received frame for one cycle.
	task automatic frame(input logic ide, input logic rtr, input logic [10:0] standard_id_bits,
		input logic [17:0] extended_id_bits);
		@(posedge core_clk_i);
		rx_frame_o <= {1'b1, ide, rtr, standard_id_bits, extended_id_bits};
		@(posedge core_clk_i);
		rx_frame_o <= {1'b0, ~ide, ~rtr, ~standard_id_bits, ~extended_id_bits};
	endtask : frame

	// Reports the outcome of a send as sent, aborted, lost or errored.
	task automatic txev(input logic [2:0] b, input logic [3:0] k);
		@(posedge core_clk_i);
		tx_event_o <= {1'b1, b, k};
		@(posedge core_clk_i);
		tx_event_o <= {1'b0, ~b, ~k};
	endtask : txev
endmodule : cfb_engine_model
`default_nettype wire

//--- cfb_ctrl_tb.sv
// Purpose: Self-checking bench for the filter, mask and buffer control block.
// Assumes: The engine model drives frames and transmit events.
// Notes: Table rows check register access; event cases follow by hand.
`timescale 1ns/1ps
`default_nettype none
module cfb_ctrl_tb
	import cfb_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} cfb_row_t;
	localparam cfb_row_t ROWS [10] = '{'{8'h00, 16'hA5C3, 16'hA5C3},
		'{8'h04, 16'h3C5A, 16'h3C5A}, '{8'h08, 16'hFFFF, 16'hFFEB},
		'{8'h0C, 16'hFFFF, 16'hFFFF}, '{8'h18, 16'hFFFF, 16'hFFEB},
		'{8'h24, 16'h1234, 16'h1234}, '{8'h34, 16'hFFFF, 16'h0000},
		'{8'h3C, 16'hFFFF, 16'h0000}, '{8'h44, 16'h00F0, 16'h0080},
		'{8'h7C, 16'hFFFF, 16'h0000}};
	logic core_clk_i;
	logic rst_n_i;
	logic rd_s;
	logic wr_s;
	logic wreq;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0] be;
	logic [15:0] got;
	cfb_rx_t rx;
	cfb_txev_t txev;
	cfb_store_t store;
	logic pick_v;
	logic [2:0] pick_b;
	logic [NUM_TXB-1:0] abort;
	int n_mismatch;
	int num_checks;

	cfb_ctrl DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.rx_frame_i(rx), .tx_event_i(txev), .rx_store_o(store),
		.tx_pick_valid_o(pick_v), .tx_pick_buf_o(pick_b), .tx_abort_o(abort));
	cfb_engine_model ENG (.core_clk_i(core_clk_i), .rx_frame_o(rx), .tx_event_o(txev));

	always #10 core_clk_i = ~core_clk_i;

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk

	// One bus access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge core_clk_i);
		addr <= a;
		wdata <= {16'h0000, d};
		be <= b;
		wr_s <= w;
		rd_s <= !w;
		do
		begin
			@(posedge core_clk_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		got = rdata[15:0];
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		if (wreq !== 1'b0)
		begin
			$display("MISMATCH waitrequest expected 0 seen %b", wreq);
			n_mismatch++;
			wrap_up();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 4'h3);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000, 4'h3);
		chk($sformatf("register %h", a), e, got);
	endtask : rdc

	task automatic gap;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : gap

	// Sends a frame and checks the store request; e bit 11 clear means no store.
	task automatic fr(input logic ide, input logic rtr, input logic [10:0] standard_id_bits,
		input logic [17:0] extended_id_bits, input logic [15:0] e);
		ENG.frame(ide, rtr, standard_id_bits, extended_id_bits);
		#1;
		if (e[11])
			chk("store", e, {4'h0, store});
		else
			chk("store valid", 16'h0000, {15'h0000, store.valid});
	endtask : fr

	initial
	begin
		core_clk_i = 1'b0;
		rst_n_i = 1'b0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		be = 4'h3;
		n_mismatch = 0;
		num_checks = 0;
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		foreach (ROWS[i])
		begin
			wr(ROWS[i].a, ROWS[i].d);
			rdc(ROWS[i].a, ROWS[i].e);
		end
		rdc(8'h00, 16'hA5C3);
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		#1;
		chk("waitrequest", 16'h0001, {15'h0000, wreq});
		chk("readdata in reset", 16'h0000, rdata[15:0]);
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rdc(8'h00, 16'h0000);
		rdc(8'h04, 16'h0000);
		rdc(8'h20, 16'hFFFF);
		rdc(8'h34, 16'h0000);
		rdc(8'h3C, 16'h0000);
		rdc(8'h44, 16'h0000);
		wr(8'h80, 16'h2460);
		wr(8'h24, 16'h0005);
		wr(8'h08, 16'hFFE0);
		wr(8'h18, 16'hFFE0);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h00, {14'h0000, 2'(c)});
			fr(1'b0, 1'b0, 11'h124, 18'h00000, (c == 1) ? 16'h08A0 : 16'h0000);
			rdc(8'h34, (c == 1) ? 16'h0020 : 16'h0000);
			wr(8'h34, 16'h0000);
		end
		wr(8'h00, 16'h0000);
		fr(1'b0, 1'b0, 11'h123, 18'h00000, 16'h08A0);
		fr(1'b0, 1'b0, 11'h123, 18'h00000, 16'h0000);
		rdc(8'h3C, 16'h0020);
		wr(8'h34, 16'hFFFF);
		rdc(8'h34, 16'h0020);
		wr(8'h3C, 16'hFFDF);
		rdc(8'h3C, 16'h0000);
		wr(8'h34, 16'hFFDF);
		wr(8'h20, 16'hFFFE);
		fr(1'b0, 1'b0, 11'h123, 18'h00000, 16'h0000);
		wr(8'h20, 16'hFFFF);
		wr(8'h08, 16'hFFE8);
		fr(1'b1, 1'b0, 11'h123, 18'h00005, 16'h0000);
		wr(8'h80, 16'h2468);
		wr(8'h84, 16'h0005);
		wr(8'h0C, 16'hFFFF);
		fr(1'b1, 1'b0, 11'h123, 18'h00004, 16'h0000);
		fr(1'b1, 1'b0, 11'h123, 18'h00005, 16'h08A0);
		wr(8'h34, 16'h0000);
		bus(1'b1, 8'h24, 16'h0707, 4'h2);
		rdc(8'h24, 16'h0705);
		wr(8'h48, 16'h0084);
		wr(8'h24, 16'h0002);
		fr(1'b1, 1'b1, 11'h123, 18'h00005, 16'h0000);
		rdc(8'h48, 16'h008C);
		wr(8'h44, 16'h8A8B);
		gap();
		chk("pick", 16'h0008, {12'h000, pick_v, pick_b});
		ENG.txev(3'h0, 4'h8);
		gap();
		chk("pick", 16'h0009, {12'h000, pick_v, pick_b});
		rdc(8'h44, 16'h8A83);
		ENG.txev(3'h1, 4'h2);
		gap();
		rdc(8'h44, 16'hAA83);
		ENG.txev(3'h1, 4'h1);
		gap();
		rdc(8'h44, 16'hBA83);
		wr(8'h44, 16'h8283);
		gap();
		chk("abort", 16'h0002, {8'h00, abort});
		ENG.txev(3'h1, 4'h4);
		gap();
		rdc(8'h44, 16'hF283);
		chk("abort", 16'h0000, {8'h00, abort});
		wr(8'h44, 16'h8A83);
		gap();
		rdc(8'h44, 16'h8A83);
		chk("pick", 16'h0009, {12'h000, pick_v, pick_b});
		wr(8'h24, 16'h000F);
		fr(1'b1, 1'b0, 11'h123, 18'h00005, 16'h0C00);
		rdc(8'h34, 16'h0000);
		wrap_up();
	end
endmodule : cfb_ctrl_tb
`default_nettype wire
